// ### mpm_pkg.sv
// Package for the multipurpose audio pin mux: register map, codes, carriers
package mpm_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] REG_SELECT = 8'h00;
  localparam logic [7:0] REG_FLAG_CHOICE = 8'h04;
  localparam logic [7:0] REG_GPIO_DIR = 8'h08;
  localparam logic [7:0] REG_GPO = 8'h0c;
  localparam logic [7:0] REG_GPI = 8'h10;
  localparam logic [7:0] REG_A_TRISTATE = 8'h14;
  localparam logic [7:0] REG_FLAG_PICK_LO = 8'h18;
  localparam logic [7:0] REG_FLAG_PICK_HI = 8'h1c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 4;
  localparam int SEL_C_LSB = 8;
  localparam int SEL_S0_LSB = 12;
  localparam int SEL_S1_LSB = 16;
  localparam int GPO_SINGLE_LSB = 12;
  localparam int PICK_LO_BITS = 24;
  localparam int PICK_HI_BITS = 12;

  // ----------------------------------------
  // Group and single pin function codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    GA_BIPHASE_IN, GA_STATUS_OUT, GA_CLOCKS_OUT, GA_FLAG_GPIO
  } mpm_a_mode_t;

  typedef enum logic [2:0] {
    GB_AUX_IN2, GB_AUX_OUT, GB_RATE_CODE, GB_FLAG_GPIO,
    GB_STATUS_SERIAL, GB_SLAVE_CONV, GB_RESERVED, GB_TEST
  } mpm_b_mode_t;

  typedef enum logic [2:0] {
    GC_AUX_IN1, GC_STANDALONE_CONV, GC_RATE_CODE, GC_FLAG_GPIO,
    GC_STATUS_SERIAL, GC_STANDALONE_XMIT, GC_RESERVED6, GC_RESERVED7
  } mpm_c_mode_t;

  localparam logic [3:0] SP_HIZ = 4'h0;
  localparam logic [3:0] SP_GPO = 4'h1;
  localparam logic [3:0] SP_MARKER = 4'h2;
  localparam logic [3:0] SP_FLAG_FIRST = 4'h3;
  localparam logic [3:0] SP_FLAG_LAST = 4'ha;
  localparam logic [3:0] SP_VALIDITY = 4'hb;
  localparam logic [3:0] SP_CRYSTAL = 4'hc;
  localparam logic [3:0] SP_XMIT = 4'hd;
  localparam logic [3:0] SP_SELECTOR0 = 4'he;
  localparam logic [3:0] SP_SELECTOR1 = 4'hf;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam mpm_a_mode_t SEL_A_RST = GA_STATUS_OUT;
  localparam mpm_b_mode_t SEL_B_RST = GB_AUX_IN2;
  localparam mpm_c_mode_t SEL_C_RST = GC_AUX_IN1;
  localparam logic [3:0] SEL_S0_RST = SP_XMIT;
  localparam logic [3:0] SEL_S1_RST = SP_VALIDITY;
  localparam logic [3:0] A_TRISTATE_RST = 4'hf;

  // Flag vector positions
  localparam int FLAG_CLOCK_TRANSIENT_STATUS = 0;
  localparam int FLAG_INTERRUPT_LINE_ZERO = 1;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic sys_clk;
    logic bit_clk;
    logic word_clk;
    logic data;
  } mpm_port_t;

  typedef struct packed {
    logic marker;
    logic chan_status;
    logic user_bits;
    logic validity;
  } mpm_serial_t;

endpackage

// ### mpm_pin_mux.sv
// Multipurpose audio pin mux: three four-pin groups, two single output pins
`timescale 1ns/1ps

module mpm_pin_mux
  import mpm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Group pins A0..A3, B0..B3, C0..C3
  input wire logic [11:0] group_pin_in,
  output logic [11:0] group_pin_out,
  output logic [11:0] group_pin_oe_out,
  // Single output pins
  output logic [1:0] single_pin_out,
  output logic [1:0] single_pin_oe_out,
  // Internal sources
  input wire logic [7:0] receiver_flags_in,
  input wire mpm_serial_t serial_status_in,
  input wire logic [3:0] sample_rate_code_in,
  input wire logic secondary_bit_clock_in,
  input wire logic secondary_word_clock_in,
  input wire logic crystal_clock_buffered_in,
  input wire mpm_port_t aux_output_port_in,
  input wire mpm_port_t slave_conv_clocks_in,
  input wire logic standalone_conv_bit_clock_in,
  input wire logic standalone_conv_word_clock_in,
  input wire logic standalone_conv_serial_data_in,
  input wire logic standalone_conv_clock_master_in,
  input wire logic biphase_selector_zero_output_in,
  input wire logic biphase_selector_one_output_in,
  input wire logic transmitter_biphase_stream_in,
  // Routed pin inputs toward internal units
  output logic [3:0] biphase_in_out,
  output mpm_port_t aux_input_port_one_out,
  output mpm_port_t aux_input_port_two_out,
  output mpm_port_t standalone_xmit_out,
  output logic xmit_from_pins_out,
  output logic standalone_conv_system_clock_out,
  output logic standalone_conv_bit_clock_out,
  output logic standalone_conv_word_clock_out,
  output logic slave_conv_serial_data_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mpm_a_mode_t a_sel;
    mpm_b_mode_t b_sel;
    mpm_c_mode_t c_sel;
    logic [3:0] s0_sel;
    logic [3:0] s1_sel;
    logic [11:0] flag_choice;
    logic [11:0] gpio_dir;
    logic [11:0] gpo;
    logic [1:0] single_gpo;
    logic [3:0] a_tristate;
    logic [35:0] flag_pick;
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] sync3;
    logic [11:0] level;
    logic [11:0] pin_o;
    logic [11:0] pin_oe;
    logic [1:0] spin_o;
    logic [1:0] spin_oe;
    logic [3:0] biphase;
    mpm_port_t aux1;
    mpm_port_t aux2;
    mpm_port_t xmit;
    logic xmit_sel;
    logic [2:0] conv_clk;
    logic slave_data;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mpm_state_t;

  mpm_state_t st;
  mpm_state_t next_st;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [11:0] fg_o;
  logic [11:0] fg_oe;
  logic [31:0] rd_data;
  logic addr_hit;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Port fields pin0..pin3 = system, bit, word, data
  function automatic mpm_port_t pins_to_port(input logic [3:0] p);
    pins_to_port = '{sys_clk: p[0], bit_clk: p[1], word_clk: p[2], data: p[3]};
  endfunction

  function automatic logic [3:0] port_to_pins(input mpm_port_t p);
    port_to_pins = {p.data, p.word_clk, p.bit_clk, p.sys_clk};
  endfunction

  function automatic logic [3:0] serial_to_pins(input mpm_serial_t s);
    serial_to_pins = {s.validity, s.user_bits, s.chan_status, s.marker};
  endfunction

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  always_comb begin
    rd_data = 32'h0;
    addr_hit = 1'b1;
    if (paddr_in == REG_SELECT) begin
      rd_data[SEL_A_LSB +: 2] = st.a_sel;
      rd_data[SEL_B_LSB +: 3] = st.b_sel;
      rd_data[SEL_C_LSB +: 3] = st.c_sel;
      rd_data[SEL_S0_LSB +: 4] = st.s0_sel;
      rd_data[SEL_S1_LSB +: 4] = st.s1_sel;
    end else if (paddr_in == REG_FLAG_CHOICE) begin
      rd_data[11:0] = st.flag_choice;
    end else if (paddr_in == REG_GPIO_DIR) begin
      rd_data[11:0] = st.gpio_dir;
    end else if (paddr_in == REG_GPO) begin
      rd_data[11:0] = st.gpo;
      rd_data[GPO_SINGLE_LSB +: 2] = st.single_gpo;
    end else if (paddr_in == REG_GPI) begin
      rd_data[11:0] = st.level;
    end else if (paddr_in == REG_A_TRISTATE) begin
      rd_data[3:0] = st.a_tristate;
    end else if (paddr_in == REG_FLAG_PICK_LO) begin
      rd_data[PICK_LO_BITS-1:0] = st.flag_pick[PICK_LO_BITS-1:0];
    end else if (paddr_in == REG_FLAG_PICK_HI) begin
      rd_data[PICK_HI_BITS-1:0] = st.flag_pick[35:PICK_LO_BITS];
    end else begin
      addr_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // Per-pin flag or GPIO choice
  // ----------------------------------------
  always_comb begin
    fg_o = 12'h0;
    fg_oe = 12'h0;
    for (int i = 0; i < 12; i++) begin
      fg_o[i] = st.flag_choice[i] ? receiver_flags_in[st.flag_pick[3*i +: 3]] : st.gpo[i];
      fg_oe[i] = st.flag_choice[i] | st.gpio_dir[i];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // Three-stage pin sampling, level moves when stages two and three agree
    next_st.sync1 = group_pin_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    next_st.level = (~(st.sync2 ^ st.sync3) & st.sync3) | ((st.sync2 ^ st.sync3) & st.level);

    // Whole group switches at once from its select field
    next_st.pin_o = 12'h0;
    next_st.pin_oe = 12'h0;

    case (st.a_sel)
      GA_BIPHASE_IN: begin
        next_st.pin_oe[3:0] = 4'h0;
      end
      GA_STATUS_OUT: begin
        next_st.pin_o[3:0] = {receiver_flags_in[FLAG_INTERRUPT_LINE_ZERO], crystal_clock_buffered_in,
                              serial_status_in.validity, receiver_flags_in[FLAG_CLOCK_TRANSIENT_STATUS]};
        next_st.pin_oe[3:0] = 4'hf;
      end
      GA_CLOCKS_OUT: begin
        next_st.pin_o[3:0] = {receiver_flags_in[FLAG_INTERRUPT_LINE_ZERO], crystal_clock_buffered_in,
                              secondary_word_clock_in, secondary_bit_clock_in};
        next_st.pin_oe[3:0] = 4'hf;
      end
      default: begin
        next_st.pin_o[3:0] = fg_o[3:0];
        next_st.pin_oe[3:0] = fg_oe[3:0];
      end
    endcase
    next_st.pin_oe[3:0] = next_st.pin_oe[3:0] & ~st.a_tristate;

    case (st.b_sel)
      GB_AUX_IN2: begin
        next_st.pin_oe[7:4] = 4'h0;
      end
      GB_AUX_OUT: begin
        next_st.pin_o[7:4] = port_to_pins(aux_output_port_in);
        next_st.pin_oe[7:4] = 4'hf;
      end
      GB_RATE_CODE: begin
        next_st.pin_o[7:4] = {sample_rate_code_in[0], sample_rate_code_in[1],
                              sample_rate_code_in[2], sample_rate_code_in[3]};
        next_st.pin_oe[7:4] = 4'hf;
      end
      GB_FLAG_GPIO: begin
        next_st.pin_o[7:4] = fg_o[7:4];
        next_st.pin_oe[7:4] = fg_oe[7:4];
      end
      GB_STATUS_SERIAL: begin
        next_st.pin_o[7:4] = serial_to_pins(serial_status_in);
        next_st.pin_oe[7:4] = 4'hf;
      end
      GB_SLAVE_CONV: begin
        next_st.pin_o[7:4] = {1'b0, slave_conv_clocks_in.word_clk, slave_conv_clocks_in.bit_clk,
                              slave_conv_clocks_in.sys_clk};
        next_st.pin_oe[7:4] = 4'h7;
      end
      default: begin
        next_st.pin_oe[7:4] = 4'h0;
      end
    endcase

    case (st.c_sel)
      GC_AUX_IN1, GC_STANDALONE_XMIT: begin
        next_st.pin_oe[11:8] = 4'h0;
      end
      GC_STANDALONE_CONV: begin
        next_st.pin_o[11:8] = {standalone_conv_serial_data_in, standalone_conv_word_clock_in,
                               standalone_conv_bit_clock_in, 1'b0};
        next_st.pin_oe[11:8] = {1'b1, {2{standalone_conv_clock_master_in}}, 1'b0};
      end
      GC_RATE_CODE: begin
        next_st.pin_o[11:8] = {sample_rate_code_in[0], sample_rate_code_in[1],
                               sample_rate_code_in[2], sample_rate_code_in[3]};
        next_st.pin_oe[11:8] = 4'hf;
      end
      GC_FLAG_GPIO: begin
        next_st.pin_o[11:8] = fg_o[11:8];
        next_st.pin_oe[11:8] = fg_oe[11:8];
      end
      GC_STATUS_SERIAL: begin
        next_st.pin_o[11:8] = serial_to_pins(serial_status_in);
        next_st.pin_oe[11:8] = 4'hf;
      end
      default: begin
        next_st.pin_oe[11:8] = 4'h0;
      end
    endcase

    // Routed inputs only live while their mode is selected
    next_st.biphase = (st.a_sel == GA_BIPHASE_IN) ? st.level[3:0] : 4'h0;
    next_st.aux2 = (st.b_sel == GB_AUX_IN2) ? pins_to_port(st.level[7:4]) : '0;
    next_st.slave_data = (st.b_sel == GB_SLAVE_CONV) ? st.level[7] : 1'b0;
    next_st.aux1 = (st.c_sel == GC_AUX_IN1) ? pins_to_port(st.level[11:8]) : '0;
    next_st.xmit_sel = (st.c_sel == GC_STANDALONE_XMIT);
    next_st.xmit = next_st.xmit_sel ? pins_to_port(st.level[11:8]) : '0;
    next_st.conv_clk = (st.c_sel == GC_STANDALONE_CONV) ? st.level[10:8] : 3'h0;

    // Single output pins
    for (int k = 0; k < 2; k++) begin
      logic [3:0] s;
      s = (k == 0) ? st.s0_sel : st.s1_sel;
      next_st.spin_oe[k] = (s != SP_HIZ);
      if (s == SP_GPO) begin
        next_st.spin_o[k] = st.single_gpo[k];
      end else if (s == SP_MARKER) begin
        next_st.spin_o[k] = serial_status_in.marker;
      end else if (s >= SP_FLAG_FIRST && s <= SP_FLAG_LAST) begin
        next_st.spin_o[k] = receiver_flags_in[3'(s - SP_FLAG_FIRST)];
      end else if (s == SP_VALIDITY) begin
        next_st.spin_o[k] = serial_status_in.validity;
      end else if (s == SP_CRYSTAL) begin
        next_st.spin_o[k] = crystal_clock_buffered_in;
      end else if (s == SP_XMIT) begin
        next_st.spin_o[k] = transmitter_biphase_stream_in;
      end else if (s == SP_SELECTOR0) begin
        next_st.spin_o[k] = biphase_selector_zero_output_in;
      end else if (s == SP_SELECTOR1) begin
        next_st.spin_o[k] = biphase_selector_one_output_in;
      end else begin
        next_st.spin_o[k] = 1'b0;
      end
    end

    // APB: one wait state, write lands at the edge that completes access
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel_in && penable_in && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !addr_hit;
      next_st.prdata = pwrite_in ? 32'h0 : rd_data;
    end
    if (psel_in && penable_in && st.pready && pwrite_in) begin
      if (paddr_in == REG_SELECT) begin
        next_st.a_sel = mpm_a_mode_t'(pwdata_in[SEL_A_LSB +: 2]);
        next_st.b_sel = mpm_b_mode_t'(pwdata_in[SEL_B_LSB +: 3]);
        next_st.c_sel = mpm_c_mode_t'(pwdata_in[SEL_C_LSB +: 3]);
        next_st.s0_sel = pwdata_in[SEL_S0_LSB +: 4];
        next_st.s1_sel = pwdata_in[SEL_S1_LSB +: 4];
      end else if (paddr_in == REG_FLAG_CHOICE) begin
        next_st.flag_choice = pwdata_in[11:0];
      end else if (paddr_in == REG_GPIO_DIR) begin
        next_st.gpio_dir = pwdata_in[11:0];
      end else if (paddr_in == REG_GPO) begin
        next_st.gpo = pwdata_in[11:0];
        next_st.single_gpo = pwdata_in[GPO_SINGLE_LSB +: 2];
      end else if (paddr_in == REG_A_TRISTATE) begin
        next_st.a_tristate = pwdata_in[3:0];
      end else if (paddr_in == REG_FLAG_PICK_LO) begin
        next_st.flag_pick[PICK_LO_BITS-1:0] = pwdata_in[PICK_LO_BITS-1:0];
      end else if (paddr_in == REG_FLAG_PICK_HI) begin
        next_st.flag_pick[35:PICK_LO_BITS] = pwdata_in[PICK_HI_BITS-1:0];
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.a_sel <= SEL_A_RST;
      st.b_sel <= SEL_B_RST;
      st.c_sel <= SEL_C_RST;
      st.s0_sel <= SEL_S0_RST;
      st.s1_sel <= SEL_S1_RST;
      st.a_tristate <= A_TRISTATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign group_pin_out = st.pin_o;
  assign group_pin_oe_out = st.pin_oe;
  assign single_pin_out = st.spin_o;
  assign single_pin_oe_out = st.spin_oe;
  assign biphase_in_out = st.biphase;
  assign aux_input_port_one_out = st.aux1;
  assign aux_input_port_two_out = st.aux2;
  assign standalone_xmit_out = st.xmit;
  assign xmit_from_pins_out = st.xmit_sel;
  assign standalone_conv_system_clock_out = st.conv_clk[0];
  assign standalone_conv_bit_clock_out = st.conv_clk[1];
  assign standalone_conv_word_clock_out = st.conv_clk[2];
  assign slave_conv_serial_data_out = st.slave_data;

endmodule // mpm_pin_mux

// ### mpm_monitor.sv
// Checker for the pin mux: APB answer timing and group pin routing
`timescale 1ns/1ps
module mpm_monitor
  import mpm_pkg::*;
(
  // Clock, reset, APB
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  // Pins and routes
  input wire logic [11:0] group_pin_out,
  input wire logic [11:0] group_pin_oe_out,
  input wire mpm_port_t aux_output_port_in,
  input wire logic [3:0] sample_rate_code_in,
  input wire logic [3:0] biphase_in_out,
  input wire logic xmit_from_pins_out
);
  logic [31:0] sel;
  logic [3:0] live;
  mpm_port_t aux_seen;
  logic [3:0] rate_seen;
  logic [2:0] sel_b;
  logic [2:0] sel_c;
  assign sel_b = sel[6:4];
  assign sel_c = sel[10:8];
  // Shadow of the select word, source values one cycle back
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel <= 32'h000bd001;
      live <= 4'h0;
      aux_seen <= '0;
      rate_seen <= 4'h0;
    end else begin
      live <= {live[2:0], 1'b1};
      aux_seen <= aux_output_port_in;
      rate_seen <= sample_rate_code_in;
      if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == REG_SELECT) begin
        sel <= pwdata_in;
      end
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!live[3]);
  apb_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("access not answered after one wait state");
  apb_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready held for more than one cycle");
  aux_out_a: assert property (sel_b == 3'h1 |=> group_pin_oe_out[7:4] == 4'hf &&
    group_pin_out[7:4] == {aux_seen.data, aux_seen.word_clk, aux_seen.bit_clk, aux_seen.sys_clk})
    else $error("aux output port not on group b");
  rate_order_a: assert property (sel_b == 3'h2 |=>
    group_pin_out[7:4] == {rate_seen[0], rate_seen[1], rate_seen[2], rate_seen[3]})
    else $error("rate code bit order wrong on group b");
  slave_conv_a: assert property (sel_b == 3'h5 |=> group_pin_oe_out[7:4] == 4'h7)
    else $error("slave converter pin directions wrong");
  b_reserved_a: assert property (sel_b[2:1] == 2'b11 |=> group_pin_oe_out[7:4] == 4'h0)
    else $error("group b driven under reserved code");
  c_reserved_a: assert property (sel_c[2:1] == 2'b11 |=> group_pin_oe_out[11:8] == 4'h0)
    else $error("group c driven under reserved code");
  xmit_mode_a: assert property (1'b1 |=> xmit_from_pins_out == ($past(sel_c) == 3'h5))
    else $error("transmitter source flag wrong");
  biphase_gate_a: assert property (sel[1:0] != 2'h0 |=> biphase_in_out == 4'h0)
    else $error("biphase inputs routed outside their mode");
  a_input_a: assert property (sel[1:0] == 2'h0 |=> group_pin_oe_out[3:0] == 4'h0)
    else $error("group a driven in biphase input mode");
endmodule // mpm_monitor

// ### mpm_far_side.sv
// Far-side model: sources on the group pins and an external slave converter
`timescale 1ns/1ps
module mpm_far_side
  import mpm_pkg::*;
(
  // Device side of the pins
  input wire logic [11:0] pin_out_in,
  input wire logic [11:0] pin_oe_in,
  // Levels the outside sources present
  input wire logic [11:0] level_in,
  // Resolved pin levels
  output logic [11:0] pin_level_out
);
  logic [15:0] word = 16'ha5c3;
  logic [11:0] ext;
  // Converter moves data on the falling bit clock it is given
  always @(negedge pin_out_in[5]) begin
    if (pin_oe_in[7:4] == 4'h7) begin
      word <= {word[14:0], word[15]};
    end
  end
  always_comb begin
    ext = level_in;
    if (pin_oe_in[7:4] == 4'h7) begin
      ext[7] = word[15];
    end
  end
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext);
endmodule // mpm_far_side

// ### multipurpose_audio_pin_mux_test.sv
// Self-checking bench for the multipurpose audio pin mux
`timescale 1ns/1ps
module multipurpose_audio_pin_mux_test;
  import mpm_pkg::*;
  // ----------------------------
  // Signals
  // ----------------------------
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, perr, xpin, cs_out, cb_out, cw_out, sdata, lclk = 1'b0, lk_en = 1'b0;
  logic [11:0] pin_in, pin_out, pin_oe, ext = 12'h5a6;
  logic [1:0] sp_out, sp_oe;
  logic [7:0] flags = 8'h02;
  mpm_serial_t ser = 4'hc;
  logic [3:0] rate = 4'h3, bi_in;
  logic secondary_bit_clock = 1'b1, swck = 1'b0, xtal = 1'b1, cbit = 1'b1, cwrd = 1'b0, cdat = 1'b1;
  logic cmst = 1'b0, bs0 = 1'b1, bs1 = 1'b0, tx = 1'b1;
  mpm_port_t aux = 4'hd, cclk, aux1, aux2, sxm;
  int n_mismatch = 0, n_compared = 0;
  always #2 clk = ~clk;
  logic [2:0] lcnt = 3'h0;
  always @(posedge clk) begin
    lcnt <= lcnt + 3'h1;
    if (lcnt == 3'h7) lclk <= lk_en & ~lclk;
  end
  assign cclk = {lclk, lclk, ~lclk, 1'b0};
  mpm_pin_mux dut (.mclk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .group_pin_in(pin_in), .group_pin_out(pin_out), .group_pin_oe_out(pin_oe), .single_pin_out(sp_out),
    .single_pin_oe_out(sp_oe), .receiver_flags_in(flags), .serial_status_in(ser), .sample_rate_code_in(rate),
    .secondary_bit_clock_in(secondary_bit_clock), .secondary_word_clock_in(swck), .crystal_clock_buffered_in(xtal),
    .aux_output_port_in(aux), .slave_conv_clocks_in(cclk), .standalone_conv_bit_clock_in(cbit),
    .standalone_conv_word_clock_in(cwrd), .standalone_conv_serial_data_in(cdat),
    .standalone_conv_clock_master_in(cmst), .biphase_selector_zero_output_in(bs0),
    .biphase_selector_one_output_in(bs1), .transmitter_biphase_stream_in(tx), .biphase_in_out(bi_in),
    .aux_input_port_one_out(aux1), .aux_input_port_two_out(aux2), .standalone_xmit_out(sxm),
    .xmit_from_pins_out(xpin), .standalone_conv_system_clock_out(cs_out),
    .standalone_conv_bit_clock_out(cb_out), .standalone_conv_word_clock_out(cw_out),
    .slave_conv_serial_data_out(sdata));
  mpm_far_side far (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .level_in(ext), .pin_level_out(pin_in));
  // ----------------------------
  // Shared tasks
  // ----------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic give_up(input logic hung);
    if (hung) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    give_up(pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("read data", x, r);
    chk("slave error", 32'(xe), 32'(e));
  endtask
  task automatic sel(input logic [1:0] a, input logic [2:0] b, input logic [2:0] c, input logic [3:0] s);
    wr(REG_SELECT, {12'h0, s, s, 1'b0, c, 1'b0, b, 2'h0, a});
    tick(8);
  endtask
  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_reset();
    rd(REG_SELECT, 32'h000bd001, 1'b0);
    rd(REG_A_TRISTATE, 32'hf, 1'b0);
    wr(REG_GPI, 32'h0);
    rd(REG_GPI, 32'(ext), 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    chk("pin enables", 32'h0, 32'(pin_oe));
    chk("single pins", 32'({2'b11, ser.validity, tx}), 32'({sp_oe, sp_out}));
  endtask
  task automatic t_group_a();
    logic [3:0] x[4];
    x = '{4'h0, {flags[FLAG_INTERRUPT_LINE_ZERO], xtal, ser.validity, flags[FLAG_CLOCK_TRANSIENT_STATUS]}, {flags[FLAG_INTERRUPT_LINE_ZERO], xtal, swck, secondary_bit_clock}, 4'h4};
    wr(REG_A_TRISTATE, 32'h0);
    wr(REG_FLAG_CHOICE, 32'h1);
    wr(REG_FLAG_PICK_LO, 32'h0);
    wr(REG_GPIO_DIR, 32'hf);
    wr(REG_GPO, 32'h5);
    for (int m = 0; m < 4; m++) begin
      sel(m[1:0], 3'h0, 3'h0, SP_XMIT);
      chk("a enables", m == 0 ? 32'h0 : 32'hf, 32'(pin_oe[3:0]));
      if (m == 0) chk("biphase in", 32'(ext[3:0]), 32'(bi_in));
      else chk("a drive", 32'(x[m]), 32'(pin_out[3:0]));
    end
    wr(REG_A_TRISTATE, 32'hf);
    tick(2);
    chk("a tristate", 32'h0, 32'(pin_oe[3:0]));
  endtask
  task automatic t_group_b();
    logic [3:0] oe_x[8];
    logic [3:0] v_x[8];
    oe_x = '{4'h0, 4'hf, 4'hf, 4'hf, 4'hf, 4'h7, 4'h0, 4'h0};
    v_x = '{4'h0, {aux.data, aux.word_clk, aux.bit_clk, aux.sys_clk}, {rate[0], rate[1], rate[2], rate[3]},
      4'ha, {ser.validity, ser.user_bits, ser.chan_status, ser.marker}, 4'h0, 4'h0, 4'h0};
    wr(REG_FLAG_CHOICE, 32'h0);
    wr(REG_GPIO_DIR, 32'hf0);
    wr(REG_GPO, 32'ha0);
    for (int m = 0; m < 8; m++) begin
      sel(2'h1, m[2:0], 3'h0, SP_XMIT);
      chk("b enables", 32'(oe_x[m]), 32'(pin_oe[7:4]));
      if (oe_x[m] == 4'hf) chk("b drive", 32'(v_x[m]), 32'(pin_out[7:4]));
      if (m == 0) chk("aux in two", 32'({ext[4], ext[5], ext[6], ext[7]}), 32'(aux2));
    end
  endtask
  task automatic t_conv();
    int i;
    lk_en <= 1'b1;
    sel(2'h1, 3'h5, 3'h0, SP_XMIT);
    for (int k = 0; k < 4; k++) begin
      i = 0;
      while (pin_out[5] !== 1'b0 && i < 40) begin
        tick(1);
        i++;
      end
      while (pin_out[5] !== 1'b1 && i < 40) begin
        tick(1);
        i++;
      end
      give_up(i >= 40);
      chk("converter data", 32'(pin_in[7]), 32'(sdata));
    end
    lk_en <= 1'b0;
  endtask
  task automatic t_group_c();
    logic [3:0] p;
    p = {ext[8], ext[9], ext[10], ext[11]};
    sel(2'h1, 3'h0, 3'h0, SP_XMIT);
    chk("aux in one", 32'(p), 32'(aux1));
    sel(2'h1, 3'h0, 3'h5, SP_XMIT);
    chk("xmit pins", 32'({1'b1, 4'h0, p}), 32'({xpin, pin_oe[11:8], sxm}));
    cmst <= 1'b1;
    sel(2'h1, 3'h0, 3'h1, SP_XMIT);
    chk("conv enables", 32'he, 32'(pin_oe[11:8]));
    chk("conv drive", 32'({cdat, cwrd, cbit, ext[8]}), 32'({pin_out[11:9], cs_out}));
    cmst <= 1'b0;
    tick(8);
    chk("conv slave", 32'({4'h8, ext[9], ext[10]}), 32'({pin_oe[11:8], cb_out, cw_out}));
    sel(2'h1, 3'h0, 3'h2, SP_XMIT);
    chk("c rate", 32'({rate[0], rate[1], rate[2], rate[3]}), 32'(pin_out[11:8]));
    sel(2'h1, 3'h0, 3'h6, SP_XMIT);
    chk("c reserved", 32'h0, 32'(pin_oe[11:8]));
    sel(2'h1, 3'h0, 3'h4, SP_XMIT);
    chk("c serial", 32'({4'hf, ser.validity, ser.user_bits, ser.chan_status, ser.marker}),
      32'({pin_oe[11:8], pin_out[11:8]}));
  endtask
  task automatic t_single();
    logic [3:0] codes[8];
    logic [1:0] x;
    codes = '{SP_HIZ, SP_GPO, SP_MARKER, SP_CRYSTAL, SP_XMIT, SP_SELECTOR0, SP_SELECTOR1, SP_FLAG_FIRST + 4'h1};
    wr(REG_GPO, 32'h2000);
    foreach (codes[k]) begin
      case (codes[k])
        SP_GPO: x = 2'b10;
        SP_MARKER: x = {2{ser.marker}};
        SP_CRYSTAL: x = {2{xtal}};
        SP_XMIT: x = {2{tx}};
        SP_SELECTOR0: x = {2{bs0}};
        SP_SELECTOR1: x = {2{bs1}};
        SP_FLAG_FIRST + 4'h1: x = {2{flags[1]}};
        default: x = 2'b00;
      endcase
      sel(2'h1, 3'h0, 3'h0, codes[k]);
      chk("single enables", codes[k] == SP_HIZ ? 32'h0 : 32'h3, 32'(sp_oe));
      if (codes[k] != SP_HIZ) chk("single drive", 32'(x), 32'(sp_out));
    end
  endtask
  initial begin
    tick(16);
    nrst <= 1'b1;
    tick(3);
    t_reset();
    t_group_a();
    t_group_b();
    t_conv();
    t_group_c();
    t_single();
    final_report();
  end
endmodule // multipurpose_audio_pin_mux_test

bind mpm_pin_mux mpm_monitor mon (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .group_pin_out(group_pin_out), .group_pin_oe_out(group_pin_oe_out),
  .aux_output_port_in(aux_output_port_in), .sample_rate_code_in(sample_rate_code_in),
  .biphase_in_out(biphase_in_out), .xmit_from_pins_out(xmit_from_pins_out));
